//--- src/eyesc_engine.sv
// Eye-scan engine top: APB register file, offset outputs and LANES lane engines (two by default).
// Assumes the lane samples arrive on the receive lane clock, which is clock_i.
`timescale 1ns/1ps
`default_nettype none
`include "eyesc_regs.svh"

module eyesc_engine #(
	parameter int LANES = 2
) (
	input  wire logic                                   clock_i,
	input  wire logic                                   rst_n_i,
	input  wire logic                                   psel,
	input  wire logic                                   penable,
	input  wire logic                                   pwrite,
	input  wire logic [`EYESC_ADDR_W-1:0]               paddr,
	input  wire logic [31:0]                            pwdata,
	output logic [31:0]                                 prdata,
	output logic                                        pready,
	output logic                                        pslverr,
	input  wire logic [LANES-1:0]                       lane_data_i,
	input  wire logic [LANES-1:0]                       lane_scan_i,
	output logic [LANES-1:0]                            lane_data_o,
	output logic [`EYESC_SLOT_W-1:0]                    bit_slot_o,
	output eyesc_pkg::eyesc_offset_type                 sampler_offset_o,
	output logic [`EYESC_SLOT_W-1:0]                    slot_count_o
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic                                 scan_run;
	logic [7:0]                           eye_scan_control;
	logic [7:0]                           eye_scan_phase_offset;
	logic [7:0]                           eye_scan_voltage_offset;
	logic [7:0]                           eye_scan_bit_slot;
	logic                                 mismatch_count_clear;
	logic                                 clear_prev;
	logic [LANES-1:0]                     scan_done_flag;
	logic [LANES-1:0][`EYESC_COUNT_W-1:0] mismatch_count;
	logic [LANES-1:0][`EYESC_VOLT_W-1:0]  auto_voltage_outcome;

	function automatic logic hit(input logic [`EYESC_ADDR_W-1:0] a, input logic [11:0] idx);
		hit = (a == `EYESC_ADDR_W'({idx, 2'b00}));
	endfunction

	wire logic [`EYESC_ADDR_W-3:0] word = paddr[`EYESC_ADDR_W-1:2];
	wire logic sel_run   = hit(paddr, `EYESC_IDX_RUN);
	wire logic sel_ctrl  = hit(paddr, `EYESC_IDX_CTRL);
	wire logic sel_phase = hit(paddr, `EYESC_IDX_PHASE);
	wire logic sel_volt  = hit(paddr, `EYESC_IDX_VOLT);
	wire logic sel_slot  = hit(paddr, `EYESC_IDX_SLOT);
	wire logic sel_clr   = hit(paddr, `EYESC_IDX_CLR);
	wire logic sel_done  = hit(paddr, `EYESC_IDX_DONE);
	wire logic [`EYESC_ADDR_W-3:0] out_off = word - (`EYESC_ADDR_W-2)'(`EYESC_IDX_OUTCOME);
	wire logic [`EYESC_ADDR_W-3:0] cnt_off = word - (`EYESC_ADDR_W-2)'(`EYESC_IDX_COUNT);
	wire logic sel_out   = (paddr[1:0] == 2'b00) && (out_off < (`EYESC_ADDR_W-2)'(LANES));
	wire logic sel_cnt   = (paddr[1:0] == 2'b00) && (cnt_off < (`EYESC_ADDR_W-2)'(LANES));
	wire logic mapped = sel_run | sel_ctrl | sel_phase | sel_volt | sel_slot | sel_clr |
	                    sel_done | sel_out | sel_cnt;
	wire logic wr = psel && penable && pwrite && mapped;
	wire logic settings_locked = scan_run;

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scan_run                <= 1'b0;
			eye_scan_control        <= `EYESC_REG_RESET;
			eye_scan_phase_offset   <= `EYESC_REG_RESET;
			eye_scan_voltage_offset <= `EYESC_REG_RESET;
			eye_scan_bit_slot       <= `EYESC_REG_RESET;
			mismatch_count_clear    <= 1'b0;
		end else if (wr) begin
			if (sel_run) scan_run <= pwdata[0];
			if (sel_clr) mismatch_count_clear <= pwdata[0];
			if (sel_ctrl && !settings_locked) eye_scan_control <= {2'b00, pwdata[5:0]};
			if (sel_phase && !settings_locked) eye_scan_phase_offset <= pwdata[7:0];
			if (sel_volt && !settings_locked) eye_scan_voltage_offset <= pwdata[7:0];
			if (sel_slot && !settings_locked) eye_scan_bit_slot <= pwdata[7:0];
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clear_prev <= 1'b0;
		end else begin
			clear_prev <= mismatch_count_clear;
		end
	end
	wire logic clear_pulse = clear_prev && !mismatch_count_clear;

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= sel_run   ? 32'(scan_run) :
			          sel_ctrl  ? 32'(eye_scan_control) :
			          sel_phase ? 32'(eye_scan_phase_offset) :
			          sel_volt  ? 32'(eye_scan_voltage_offset) :
			          sel_slot  ? 32'(eye_scan_bit_slot) :
			          sel_clr   ? 32'(mismatch_count_clear) :
			          sel_done  ? 32'(scan_done_flag) :
			          sel_out   ? 32'(auto_voltage_outcome[out_off[$clog2(LANES+1)-1:0]]) :
			          sel_cnt   ? 32'(mismatch_count[cnt_off[$clog2(LANES+1)-1:0]]) : 32'h00000000;
		end
	end

	// ------------------------------------------------------------
	// Bit slot tracking and sampler offsets
	// ------------------------------------------------------------
	logic [`EYESC_SLOT_W-1:0] slot_count;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			slot_count <= '0;
		end else begin
			slot_count <= (slot_count == `EYESC_SLOT_LAST) ? '0 : slot_count + `EYESC_SLOT_W'(1);
		end
	end
	wire logic slot_hit = (slot_count == eye_scan_bit_slot[`EYESC_SLOT_W-1:0]);
	wire logic auto_mode = eye_scan_control[3];

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sampler_offset_o <= '0;
			bit_slot_o       <= '0;
			slot_count_o     <= '0;
			lane_data_o      <= '0;
		end else begin
			sampler_offset_o.phase <= eye_scan_phase_offset[`EYESC_PHASE_W-1:0];
			sampler_offset_o.volt  <= auto_mode ? auto_voltage_outcome[0]
			                                    : eye_scan_voltage_offset[`EYESC_VOLT_W-1:0];
			bit_slot_o   <= eye_scan_bit_slot[`EYESC_SLOT_W-1:0];
			slot_count_o <= slot_count;
			lane_data_o  <= lane_data_i;
		end
	end

	// ------------------------------------------------------------
	// Lanes
	// ------------------------------------------------------------
	logic [LANES-1:0] scan_q1, scan_q2;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scan_q1 <= '0;
			scan_q2 <= '0;
		end else begin
			scan_q1 <= lane_scan_i;
			scan_q2 <= scan_q1;
		end
	end

	wire logic [`EYESC_SAMPLE_W-1:0] length =
		(eye_scan_control[5:4] == 2'h0) ? `EYESC_LEN0 :
		(eye_scan_control[5:4] == 2'h1) ? `EYESC_LEN1 :
		(eye_scan_control[5:4] == 2'h2) ? `EYESC_LEN2 : `EYESC_LEN3;

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			eyesc_lane u_lane (
				.clock_i    (clock_i),
				.rst_n_i    (rst_n_i),
				.run_i      (scan_run),
				.clear_i    (clear_pulse),
				.mode_i     (eye_scan_control[3:0]),
				.length_i   (length),
				.slot_hit_i (slot_hit),
				.sample_i   ({lane_data_i[g], scan_q2[g], slot_count}),
				.done_o     (scan_done_flag[g]),
				.count_o    (mismatch_count[g]),
				.outcome_o  (auto_voltage_outcome[g])
			);
		end
	endgenerate

	property p_lock;
		@(posedge clock_i) disable iff (!rst_n_i)
		scan_run |=> $stable(eye_scan_control);
	endproperty
	a_lock: assert property (p_lock) else $error("control changed while running");

	property p_len;
		@(posedge clock_i) disable iff (!rst_n_i)
		(eye_scan_control[5:4] == 2'h1) |-> (length == 17'h00408);
	endproperty
	a_len: assert property (p_len) else $error("wrong length");

	property p_reserved;
		@(posedge clock_i) disable iff (!rst_n_i)
		(eye_scan_control[3:0] == 4'h5 && !scan_done_flag[0]) |=> !scan_done_flag[0];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved mode ran");

	property p_passthru;
		@(posedge clock_i) disable iff (!rst_n_i)
		1'b1 |=> (lane_data_o == $past(lane_data_i));
	endproperty
	a_passthru: assert property (p_passthru) else $error("data path disturbed");

	property p_clearseq;
		@(posedge clock_i) disable iff (!rst_n_i)
		(clear_prev && !mismatch_count_clear) |=> (mismatch_count[0] == '0);
	endproperty
	a_clearseq: assert property (p_clearseq) else $error("counters not cleared");

	sequence s_clear_fall;
		mismatch_count_clear ##1 !mismatch_count_clear;
	endsequence

	sequence s_ctrl_write;
		psel && penable && pwrite && sel_ctrl && !scan_run;
	endsequence

	property p_clear_all;
		@(posedge clock_i) disable iff (!rst_n_i)
		s_clear_fall |=> (mismatch_count == '0);
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("some lane counter not cleared");

	property p_ctrl_write;
		@(posedge clock_i) disable iff (!rst_n_i)
		s_ctrl_write |=> (eye_scan_control == {2'b00, $past(pwdata[5:0])});
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	property p_run_set;
		@(posedge clock_i) disable iff (!rst_n_i)
		(psel && penable && pwrite && sel_run && pwdata[0]) |=> scan_run;
	endproperty
	a_run_set: assert property (p_run_set) else $error("run bit not set");

	property p_lock_offsets;
		@(posedge clock_i) disable iff (!rst_n_i)
		scan_run |=> ($stable(eye_scan_phase_offset) && $stable(eye_scan_voltage_offset));
	endproperty
	a_lock_offsets: assert property (p_lock_offsets) else $error("offsets changed while running");

	property p_lock_slot;
		@(posedge clock_i) disable iff (!rst_n_i)
		scan_run |=> $stable(eye_scan_bit_slot);
	endproperty
	a_lock_slot: assert property (p_lock_slot) else $error("bit slot changed while running");

	property p_slot_wrap;
		@(posedge clock_i) disable iff (!rst_n_i)
		(slot_count == `EYESC_SLOT_LAST) |=> (slot_count == '0);
	endproperty
	a_slot_wrap: assert property (p_slot_wrap) else $error("slot counter did not wrap");

	property p_slot_range;
		@(posedge clock_i) disable iff (!rst_n_i)
		1'b1 |-> (slot_count <= `EYESC_SLOT_LAST);
	endproperty
	a_slot_range: assert property (p_slot_range) else $error("slot counter out of range");

	property p_phase_out;
		@(posedge clock_i) disable iff (!rst_n_i)
		1'b1 |=> (sampler_offset_o.phase == $past(eye_scan_phase_offset[`EYESC_PHASE_W-1:0]));
	endproperty
	a_phase_out: assert property (p_phase_out) else $error("phase offset not applied");

	property p_volt_out;
		@(posedge clock_i) disable iff (!rst_n_i)
		!auto_mode |=> (sampler_offset_o.volt == $past(eye_scan_voltage_offset[`EYESC_VOLT_W-1:0]));
	endproperty
	a_volt_out: assert property (p_volt_out) else $error("voltage offset not applied");

	property p_volt_auto;
		@(posedge clock_i) disable iff (!rst_n_i)
		auto_mode |=> (sampler_offset_o.volt == $past(auto_voltage_outcome[0]));
	endproperty
	a_volt_auto: assert property (p_volt_auto) else $error("search result not applied");

	property p_done_clear;
		@(posedge clock_i) disable iff (!rst_n_i)
		!scan_run |=> (scan_done_flag == '0);
	endproperty
	a_done_clear: assert property (p_done_clear) else $error("done flag held after stop");

endmodule
`default_nettype wire

//--- src/eyesc_lane.sv
// One lane of the eye-scan engine: sample counting, mismatch counting and voltage search.
// Assumes sample inputs on the engine clock; run and mode stay fixed while a scan runs.
`timescale 1ns/1ps
`default_nettype none
`include "eyesc_regs.svh"

module eyesc_lane (
	input  wire logic                        clock_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        run_i,
	input  wire logic                        clear_i,
	input  wire logic [3:0]                  mode_i,
	input  wire logic [`EYESC_SAMPLE_W-1:0]  length_i,
	input  wire logic                        slot_hit_i,
	input  wire eyesc_pkg::eyesc_sample_type sample_i,
	output logic                             done_o,
	output logic [`EYESC_COUNT_W-1:0]        count_o,
	output logic [`EYESC_VOLT_W-1:0]         outcome_o
);

	// ------------------------------------------------------------
	// Sample qualification
	// ------------------------------------------------------------
	eyesc_pkg::eyesc_state_type      state;
	logic [`EYESC_SAMPLE_W-1:0]      seen;
	wire  logic d = sample_i.data_bit;
	wire  logic e = sample_i.scan_bit;
	wire  logic auto_mode = mode_i[3];
	wire  logic want_one  = mode_i[2];
	wire  logic zero_only = (mode_i == 4'h2) || (auto_mode && !want_one);
	wire  logic one_only  = (mode_i == 4'h3) || (auto_mode && want_one);
	wire  logic valid_mode = (mode_i inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'hc, 4'hd, 4'he});
	wire  logic take = (state == eyesc_pkg::EYESC_SCAN) && slot_hit_i &&
	                   !(zero_only && d) && !(one_only && !d);
	wire  logic bump = take && ((mode_i == 4'h4) ? e : (!auto_mode && (d != e)));
	wire  logic last = take && (seen == length_i - `EYESC_SAMPLE_W'(1));
	wire  logic [1:0] kind = mode_i[1:0];
	wire  logic above = e == d;
	wire  logic step_up = (kind == 2'h0) ? (want_one ? above : !above) :
	                      (kind == 2'h1) ? want_one  : !want_one;
	wire  logic may_move = (kind == 2'h0) || (kind == 2'h1 ? above : !above);
	wire  logic start = (state == eyesc_pkg::EYESC_IDLE) && run_i && valid_mode;
	wire  logic [`EYESC_VOLT_W-1:0] seed = (kind == 2'h0) ? '0 : (step_up ? `EYESC_VOLT_MIN : `EYESC_VOLT_MAX);

	// ------------------------------------------------------------
	// Run sequencing
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= eyesc_pkg::EYESC_IDLE;
			seen  <= '0;
		end else begin
			case (state)
				eyesc_pkg::EYESC_IDLE: begin
					seen <= '0;
					if (run_i && valid_mode) begin
						state <= eyesc_pkg::EYESC_SCAN;
					end
				end
				eyesc_pkg::EYESC_SCAN: begin
					if (!run_i) begin
						state <= eyesc_pkg::EYESC_IDLE;
					end else if (last) begin
						state <= eyesc_pkg::EYESC_DONE;
					end
					if (take) begin
						seen <= seen + `EYESC_SAMPLE_W'(1);
					end
				end
				eyesc_pkg::EYESC_DONE: begin
					if (!run_i) begin
						state <= eyesc_pkg::EYESC_IDLE;
					end
				end
				default: state <= eyesc_pkg::EYESC_IDLE;
			endcase
		end
	end

	assign done_o = (state == eyesc_pkg::EYESC_DONE);

	// ------------------------------------------------------------
	// Counter and voltage search
	// ------------------------------------------------------------
	wire logic signed [`EYESC_VOLT_W-1:0] vs = outcome_o;
	wire logic at_max = (outcome_o == `EYESC_VOLT_MAX);
	wire logic at_min = (outcome_o == `EYESC_VOLT_MIN);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_o   <= '0;
			outcome_o <= '0;
		end else begin
			if (clear_i) begin
				count_o <= '0;
			end else if (bump && count_o != `EYESC_COUNT_MAX) begin
				count_o <= count_o + `EYESC_COUNT_W'(1);
			end
			if (start && auto_mode) begin
				outcome_o <= seed;
			end else if (take && auto_mode && may_move) begin
				if (step_up && !at_max) begin
					outcome_o <= `EYESC_VOLT_W'(vs + 6'sd1);
				end else if (!step_up && !at_min) begin
					outcome_o <= `EYESC_VOLT_W'(vs - 6'sd1);
				end
			end
		end
	end

	property p_count_sat;
		@(posedge clock_i) disable iff (!rst_n_i)
		(count_o == `EYESC_COUNT_MAX && !clear_i) |=> (count_o == `EYESC_COUNT_MAX);
	endproperty
	a_count_sat: assert property (p_count_sat) else $error("count wrapped");

	property p_no_count_off;
		@(posedge clock_i) disable iff (!rst_n_i)
		(mode_i == 4'h0 && !clear_i) |=> $stable(count_o);
	endproperty
	a_no_count_off: assert property (p_no_count_off) else $error("count moved while disabled");

	property p_auto_no_count;
		@(posedge clock_i) disable iff (!rst_n_i)
		(auto_mode && !clear_i && $stable(mode_i)) |=> $stable(count_o);
	endproperty
	a_auto_no_count: assert property (p_auto_no_count) else $error("count moved in search mode");

	property p_zero_only;
		@(posedge clock_i) disable iff (!rst_n_i)
		(mode_i == 4'h2 && d) |-> !take;
	endproperty
	a_zero_only: assert property (p_zero_only) else $error("one sample taken in zero mode");

	property p_clear;
		@(posedge clock_i) disable iff (!rst_n_i)
		clear_i |=> (count_o == '0);
	endproperty
	a_clear: assert property (p_clear) else $error("count not cleared");

endmodule
`default_nettype wire

//--- src/eyesc_pkg.sv
// Types shared by the eye-scan engine files.
// Assumes the register header is compiled alongside.
package eyesc_pkg;

	typedef enum logic [3:0] {
		EYESC_OFF       = 4'b0000,
		EYESC_CMP_ALL   = 4'b0001,
		EYESC_CMP_ZERO  = 4'b0010,
		EYESC_CMP_ONE   = 4'b0011,
		EYESC_CNT_ONE   = 4'b0100,
		EYESC_AVG_ZERO  = 4'b1000,
		EYESC_OUT_ZERO  = 4'b1001,
		EYESC_IN_ZERO   = 4'b1010,
		EYESC_AVG_ONE   = 4'b1100,
		EYESC_OUT_ONE   = 4'b1101,
		EYESC_IN_ONE    = 4'b1110
	} eyesc_mode_type;

	typedef enum logic [1:0] {
		EYESC_IDLE = 2'b00,
		EYESC_SCAN = 2'b01,
		EYESC_DONE = 2'b10
	} eyesc_state_type;

	typedef struct packed {
		logic                    data_bit;
		logic                    scan_bit;
		logic [4:0]              slot;
	} eyesc_sample_type;

	typedef struct packed {
		logic signed [6:0]       phase;
		logic signed [5:0]       volt;
	} eyesc_offset_type;

endpackage

//--- src/eyesc_regs.svh
// Register offsets, field positions, reset values and counts of the eye-scan engine.
// Assumes byte addresses on a 32-bit APB bus, four times the printed register index.
`ifndef EYESC_REGS_SVH
`define EYESC_REGS_SVH

`define EYESC_IDX_RUN        12'h1f0
`define EYESC_IDX_CTRL       12'h1f1
`define EYESC_IDX_PHASE      12'h1f2
`define EYESC_IDX_VOLT       12'h1f3
`define EYESC_IDX_SLOT       12'h1f4
`define EYESC_IDX_CLR        12'h1f5
`define EYESC_IDX_DONE       12'h1f6
`define EYESC_IDX_OUTCOME    12'h200
`define EYESC_IDX_COUNT      12'h210
`define EYESC_ADDR_W         14

`define EYESC_MODE_LSB       0
`define EYESC_MODE_W         4
`define EYESC_LEN_LSB        4
`define EYESC_LEN_W          2
`define EYESC_PHASE_W        7
`define EYESC_VOLT_W         6
`define EYESC_SLOT_W         5
`define EYESC_SLOT_LAST      5'h13
`define EYESC_REG_RESET      8'h00

`define EYESC_LEN0           17'h0007f
`define EYESC_LEN1           17'h00408
`define EYESC_LEN2           17'h01fff
`define EYESC_LEN3           17'h0ffff
`define EYESC_SAMPLE_W       17
`define EYESC_COUNT_W        16
`define EYESC_COUNT_MAX      16'hffff
`define EYESC_VOLT_MAX       6'h1f
`define EYESC_VOLT_MIN       6'h20

`endif

//--- testbench/eyesc_engine_test.sv
// Self-checking bench for the eye-scan engine top, driving APB and both lane inputs.
// Assumes the design files under src/ and a single 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "eyesc_regs.svh"

module eyesc_engine_test;
	logic                        clock_i;
	logic                        rst_n_i;
	logic                        psel;
	logic                        penable;
	logic                        pwrite;
	logic [`EYESC_ADDR_W-1:0]    paddr;
	logic [31:0]                 pwdata;
	logic [31:0]                 prdata;
	logic                        pready;
	logic                        pslverr;
	logic [1:0]                  lane_data_i;
	logic [1:0]                  lane_scan_i;
	logic [1:0]                  lane_data_o;
	logic [4:0]                  bit_slot_o;
	eyesc_pkg::eyesc_offset_type sampler_offset_o;
	logic [4:0]                  slot_count_o;
	logic [1:0]                  last_data;
	logic                        mon_on;
	logic [31:0]                 rdata;
	logic                        rerr;
	int                          n_errors;
	int                          total_checks;

	eyesc_engine #(.LANES(2)) u_eyesc_engine (
		.clock_i             (clock_i),
		.rst_n_i             (rst_n_i),
		.psel                (psel),
		.penable             (penable),
		.pwrite              (pwrite),
		.paddr               (paddr),
		.pwdata              (pwdata),
		.prdata              (prdata),
		.pready              (pready),
		.pslverr             (pslverr),
		.lane_data_i         (lane_data_i),
		.lane_scan_i         (lane_scan_i),
		.lane_data_o         (lane_data_o),
		.bit_slot_o          (bit_slot_o),
		.sampler_offset_o    (sampler_offset_o),
		.slot_count_o        (slot_count_o)
	);

	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	// ----------------------------------------
	// Helpers.
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [13:0] ra(input logic [11:0] idx);
		return {idx, 2'b00};
	endfunction

	task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do begin
			@(posedge clock_i);
		end while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] idx, input logic [31:0] d);
		apb(1'b1, ra(idx), d);
	endtask

	task automatic rd(input logic [11:0] idx);
		apb(1'b0, ra(idx), 32'h0);
	endtask

	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	task automatic reg_test();
		logic [11:0] idx [5];
		int i;
		idx = '{`EYESC_IDX_RUN, `EYESC_IDX_CTRL, `EYESC_IDX_PHASE, `EYESC_IDX_VOLT, `EYESC_IDX_SLOT};
		for (i = 0; i < 5; i++) begin
			rd(idx[i]);
			chk(rdata, 32'h0, "reset value");
		end
		wr(`EYESC_IDX_PHASE, 32'h40);
		wr(`EYESC_IDX_VOLT, 32'h20);
		wr(`EYESC_IDX_SLOT, 32'h13);
		rd(`EYESC_IDX_PHASE);
		chk(rdata & 32'h7f, 32'h40, "phase readback");
		rd(`EYESC_IDX_VOLT);
		chk(rdata & 32'h3f, 32'h20, "voltage readback");
		rd(`EYESC_IDX_SLOT);
		chk(rdata & 32'h1f, 32'h13, "slot readback");
		chk({25'h0, sampler_offset_o.phase}, 32'h40, "phase output");
		chk({26'h0, sampler_offset_o.volt}, 32'h20, "voltage output");
		chk({27'h0, bit_slot_o}, 32'h13, "slot output");
		wr(`EYESC_IDX_PHASE, 32'h3f);
		wr(`EYESC_IDX_VOLT, 32'h1f);
		repeat (2) @(posedge clock_i);
		chk({19'h0, sampler_offset_o}, {19'h0, 7'h3f, 6'h1f}, "positive offsets");
		rd(12'h1f8);
		chk({31'h0, rerr}, 32'h1, "unmapped error");
		$display("test registers finished");
	endtask

	task automatic wait_done(input logic [1:0] want, input int limit);
		int i;
		for (i = 0; i < limit; i++) begin
			rd(`EYESC_IDX_DONE);
			if (want != 2'b00 && (rdata[1:0] & want) === want) break;
		end
		chk({30'h0, rdata[1:0]}, {30'h0, want}, "done flags");
	endtask

	task automatic run_case(input logic [3:0] mode, input logic [1:0] len, input logic [1:0] want,
			input logic [15:0] c0, input logic [15:0] c1, input int limit);
		int l;
		wr(`EYESC_IDX_CTRL, {26'h0, len, mode});
		wr(`EYESC_IDX_RUN, 32'h1);
		wait_done(want, limit);
		for (l = 0; l < 2; l++) begin
			if (want[l] && !mode[3]) begin
				rd(`EYESC_IDX_COUNT + 12'(l));
				chk(rdata & 32'hffff, {16'h0, (l == 0) ? c0 : c1}, "mismatch count");
			end
			if (want[l] && mode[3]) begin
				rd(`EYESC_IDX_OUTCOME + 12'(l));
				chk(rdata & 32'h3f, {26'h0, `EYESC_VOLT_MAX}, "search outcome");
			end
		end
		if (want[0] && mode[3]) begin
			chk({26'h0, sampler_offset_o.volt}, {26'h0, `EYESC_VOLT_MAX}, "offset follows search");
		end
		wr(`EYESC_IDX_RUN, 32'h0);
		rd(`EYESC_IDX_DONE);
		chk(rdata & 32'h3, 32'h0, "done after stop");
		wr(`EYESC_IDX_CLR, 32'h1);
		wr(`EYESC_IDX_CLR, 32'h0);
		rd(`EYESC_IDX_COUNT);
		chk(rdata & 32'hffff, 32'h0, "cleared count");
		$display("test mode %0d length %0d finished", mode, len);
	endtask

	// ----------------------------------------
	// Monitor, watchdog and verdict.
	// ----------------------------------------
	always @(posedge clock_i) begin
		if (mon_on && rst_n_i) begin
			chk({30'h0, lane_data_o}, {30'h0, last_data}, "data pass-through");
		end
		last_data <= lane_data_i;
		mon_on <= rst_n_i;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		#1700000;
		n_errors++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		results();
	end

	initial begin
		logic [3:0] bad [6];
		int i;
		bad = '{4'h0, 4'h5, 4'h6, 4'h7, 4'hb, 4'hf};
		rst_n_i = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0;
		lane_data_i = 2'b00;
		lane_scan_i = 2'b00;
		last_data = 2'b00;
		mon_on = 1'b0;
		n_errors = 0;
		total_checks = 0;
		repeat (5) @(posedge clock_i);
		rst_n_i <= 1'b1;
		reg_test();
		for (i = 0; i < 8; i++) begin
			@(posedge clock_i);
			lane_data_i <= i[1:0];
		end
		@(posedge clock_i);
		lane_data_i <= 2'b10;
		lane_scan_i <= 2'b11;
		run_case(4'h1, 2'h0, 2'b11, 16'd127, 16'd0, 1000);
		run_case(4'h2, 2'h0, 2'b01, 16'd127, 16'd0, 1000);
		run_case(4'h3, 2'h0, 2'b10, 16'd0, 16'd0, 1000);
		run_case(4'h4, 2'h0, 2'b11, 16'd127, 16'd127, 1000);
		run_case(4'h4, 2'h1, 2'b11, 16'd1032, 16'd1032, 8000);
		wr(`EYESC_IDX_VOLT, 32'h0);
		run_case(4'h8, 2'h0, 2'b01, 16'd0, 16'd0, 1000);
		run_case(4'h9, 2'h0, 2'b01, 16'd0, 16'd0, 1000);
		run_case(4'ha, 2'h0, 2'b01, 16'd0, 16'd0, 1000);
		run_case(4'hc, 2'h0, 2'b10, 16'd0, 16'd0, 1000);
		run_case(4'hd, 2'h0, 2'b10, 16'd0, 16'd0, 1000);
		run_case(4'he, 2'h0, 2'b10, 16'd0, 16'd0, 1000);
		for (i = 0; i < 6; i++) begin
			run_case(bad[i], 2'h0, 2'b00, 16'd0, 16'd0, 1000);
		end
		results();
	end
endmodule
`default_nettype wire
